/* File: rtl/cpc_config_ctrl.sv */
`timescale 1ns/10ps
// Contract
// - during configuration user pins float with weak pull-up on
// - reset pin during configuration restarts the load from scratch
// - after configuration reset pin is plain input or global set/reset
// - master and async peripheral modes drive the configuration clock
// - completion pin is open-drain, released high only when finished
// - start-up waits while anybody holds the completion pin low
// - low program input restarts configuration and resets scan logic
// - low readback trigger during configuration floats all pins
// - option decides whether trigger floats pins after configuration
// - with readback on, trigger fall starts readback from frame zero
// - serial out carries readback data, else scan test data
// - peripheral mode shows ready; async read shows it on status bit
// - master parallel mode drives a read strobe on ready pin
// - serial modes shift serial input on configuration clock
// - options time completion release and later pin release
// - configuration pins return to user pins when done
// - init pin held low while configuration memory clears
// - external low on init pin holds the wait state
// - mode pins latched on rising init pin
// - status bit high is ready, low is busy
module cpc_config_ctrl #(
    parameter int LEN_W = 16,
    parameter int ADDR_OUT_W = 18
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire cpc_pkg::cpc_pins_t pins_in,
    input wire logic tdo_in,
    input wire logic rb_data_in,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic init_out,
    output logic init_oe,
    output logic done_out,
    output logic done_oe,
    output logic config_clock_out,
    output logic config_clock_oe,
    output logic ready_out,
    output logic ready_oe,
    output logic status_data_bit,
    output logic status_data_oe,
    output logic [ADDR_OUT_W-1:0] mem_addr,
    output logic serial_out,
    output logic [7:0] cfg_byte,
    output logic cfg_byte_vld,
    output logic global_three_state,
    output logic user_io_en,
    output logic weak_pullup_en,
    output logic logic_cell_set_reset,
    output logic user_reset_in,
    output logic scan_reset,
    output logic rb_start,
    output logic rb_active
);
    import cpc_pkg::*;

    // ****************************************
    // synchronisers
    // ****************************************
    cpc_pins_t s1_q, s2_q, s3_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
        end else begin
            s1_q <= pins_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    cpc_state_t st_q;
    logic [2:0] mode_q;
    logic [2:0] ctrl_q;
    logic [LEN_W-1:0] len_q, cnt_q;
    logic [7:0] time_q;
    logic [15:0] clr_q;
    logic [3:0] dly_q;
    logic [7:0] config_clock_div_q;
    logic config_clock_q, tick_q, rdy_q;
    logic [2:0] bit_q;
    logic [7:0] sh_q;
    logic [ADDR_OUT_W-1:0] rb_addr_q;

    wire in_cfg = st_q != ST_USER;
    wire drive_clk = mode_q == CPC_MODE_MSER || mode_q == CPC_MODE_MPAR ||
        mode_q == CPC_MODE_APER;
    wire serial_mode = mode_q == CPC_MODE_MSER || mode_q == CPC_MODE_SSER;
    wire periph = mode_q == CPC_MODE_APER || mode_q == CPC_MODE_SPER;
    wire sel = !s2_q.cs0_n && s2_q.cs1;
    wire wr_fall = !s2_q.wr_n && s3_q.wr_n;
    wire init_rise = s2_q.init && !s3_q.init;
    wire trig_fall = !s2_q.rb_trig_n && s3_q.rb_trig_n;
    wire restart = !s2_q.program_restart_n || (s2_q.reset && in_cfg &&
        st_q != ST_CLEAR);
    // bytes: async peripheral takes them on write, others on clock tick
    wire take = st_q == ST_LOAD && (mode_q == CPC_MODE_APER ?
        (wr_fall && sel) : (tick_q && (mode_q != CPC_MODE_SPAR ||
        (sel && !s2_q.wr_n))));
    wire byte_done = take && (!serial_mode || bit_q == 3'h7);

    // ****************************************
    // register port
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_q <= CPC_CTRL_RST;
            len_q <= LEN_W'(CPC_LEN_RST);
            time_q <= CPC_TIME_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                CPC_REG_CTRL: ctrl_q <= reg_wdata[2:0];
                CPC_REG_LEN: len_q <= reg_wdata[LEN_W-1:0];
                CPC_REG_TIME: time_q <= reg_wdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                CPC_REG_CTRL: reg_rdata <= {29'h0, ctrl_q};
                CPC_REG_LEN: reg_rdata <= 32'(len_q);
                CPC_REG_TIME: reg_rdata <= {24'h0, time_q};
                CPC_REG_STAT: reg_rdata <= (32'(cnt_q) << CPC_STAT_CNT_POS) |
                    (32'(mode_q) << CPC_STAT_MODE_POS) | 32'(st_q);
                default: reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    // delays count configuration clock ticks, so a stopped slave clock
    // also stalls start-up, as a real part would
    always_ff @(posedge clk) begin
        if (sys_rst || restart) begin
            st_q <= ST_CLEAR;
            clr_q <= 16'h0;
            dly_q <= 4'h0;
            cnt_q <= '0;
        end else begin
            case (st_q)
                ST_CLEAR: begin
                    clr_q <= clr_q + 16'h1;
                    if (clr_q == 16'(CPC_CLEAR_CYC - 1))
                        st_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    cnt_q <= '0;
                    if (init_rise)
                        st_q <= ST_LOAD;
                end
                ST_LOAD: begin
                    if (byte_done) begin
                        cnt_q <= cnt_q + LEN_W'(1);
                        if (cnt_q == len_q - LEN_W'(1))
                            st_q <= ST_DONE_DLY;
                    end
                end
                ST_DONE_DLY: begin
                    if (tick_q)
                        dly_q <= dly_q + 4'h1;
                    if (dly_q >= time_q[CPC_TIME_DONE_POS+:4]) begin
                        st_q <= ST_DONE_WAIT;
                        dly_q <= 4'h0;
                    end
                end
                ST_DONE_WAIT: begin
                    if (s2_q.done)
                        st_q <= ST_STARTUP;
                end
                ST_STARTUP: begin
                    if (tick_q)
                        dly_q <= dly_q + 4'h1;
                    if (dly_q >= time_q[CPC_TIME_REL_POS+:4])
                        st_q <= ST_USER;
                end
                ST_USER: ;
                default: st_q <= ST_CLEAR;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_q <= CPC_MODE_MSER;
        end else if (st_q == ST_WAIT && init_rise) begin
            mode_q <= s2_q.config_mode_select;
        end
    end

    // ****************************************
    // configuration clock
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst || !drive_clk || st_q == ST_USER ||
            st_q == ST_CLEAR || st_q == ST_WAIT) begin
            config_clock_div_q <= 8'h0;
            config_clock_q <= 1'b0;
        end else if (config_clock_div_q == 8'(CPC_CONFIG_CLOCK_HALF_CYC - 1)) begin
            config_clock_div_q <= 8'h0;
            config_clock_q <= !config_clock_q;
        end else begin
            config_clock_div_q <= config_clock_div_q + 8'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tick_q <= 1'b0;
        end else if (drive_clk) begin
            tick_q <= !config_clock_q && config_clock_div_q == 8'(CPC_CONFIG_CLOCK_HALF_CYC - 1);
        end else begin
            tick_q <= s2_q.config_clock && !s3_q.config_clock;
        end
    end

    // ****************************************
    // data path
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst || st_q != ST_LOAD) begin
            bit_q <= 3'h0;
            sh_q <= 8'h0;
            cfg_byte <= 8'h0;
            cfg_byte_vld <= 1'b0;
        end else begin
            cfg_byte_vld <= byte_done;
            if (take && serial_mode) begin
                sh_q <= {sh_q[6:0], s2_q.lsb_data_bit};
                bit_q <= bit_q + 3'h1;
                if (bit_q == 3'h7)
                    cfg_byte <= {sh_q[6:0], s2_q.lsb_data_bit};
            end else if (take) begin
                cfg_byte <= {s2_q.data_hi, s2_q.lsb_data_bit};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || st_q != ST_LOAD) begin
            mem_addr <= '0;
        end else if (mode_q == CPC_MODE_MPAR && byte_done) begin
            mem_addr <= mem_addr + ADDR_OUT_W'(1);
        end
    end

    // ready drops on a byte written in async peripheral mode and returns on the next clock tick
    always_ff @(posedge clk) begin
        if (sys_rst || st_q != ST_LOAD) begin
            rdy_q <= 1'b1;
        end else if (mode_q == CPC_MODE_APER && wr_fall && sel) begin
            rdy_q <= 1'b0;
        end else if (tick_q) begin
            rdy_q <= 1'b1;
        end
    end

    // ****************************************
    // configuration pins
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            init_out <= 1'b0;
            init_oe <= 1'b1;
            done_out <= 1'b0;
            done_oe <= 1'b1;
            config_clock_out <= 1'b0;
            config_clock_oe <= 1'b0;
            ready_out <= 1'b0;
            ready_oe <= 1'b0;
            status_data_bit <= 1'b0;
            status_data_oe <= 1'b0;
        end else begin
            init_out <= 1'b0;
            init_oe <= st_q == ST_CLEAR;
            done_out <= 1'b0;
            done_oe <= st_q == ST_CLEAR || st_q == ST_WAIT ||
                st_q == ST_LOAD || st_q == ST_DONE_DLY;
            config_clock_out <= config_clock_q;
            config_clock_oe <= drive_clk && in_cfg && st_q != ST_CLEAR &&
                st_q != ST_WAIT;
            ready_out <= mode_q == CPC_MODE_MPAR ? tick_q : rdy_q;
            ready_oe <= st_q == ST_LOAD &&
                (periph || mode_q == CPC_MODE_MPAR);
            status_data_bit <= rdy_q;
            // a concurrent write wins over the status read
            status_data_oe <= st_q == ST_LOAD && mode_q == CPC_MODE_APER &&
                sel && !s2_q.rd_n && s2_q.wr_n;
        end
    end

    // ****************************************
    // user side and readback
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            global_three_state <= 1'b1;
            user_io_en <= 1'b0;
            weak_pullup_en <= 1'b1;
            logic_cell_set_reset <= 1'b0;
            user_reset_in <= 1'b0;
            scan_reset <= 1'b1;
        end else begin
            global_three_state <= !s2_q.rb_trig_n && (in_cfg ||
                ctrl_q[CPC_CTRL_TS_POS]);
            // trigger only floats user pins when the option allows it
            user_io_en <= st_q == ST_USER && (s2_q.rb_trig_n ||
                !ctrl_q[CPC_CTRL_TS_POS]);
            weak_pullup_en <= in_cfg;
            logic_cell_set_reset <= st_q == ST_USER && s2_q.reset &&
                ctrl_q[CPC_CTRL_GSR_POS];
            user_reset_in <= st_q == ST_USER && s2_q.reset;
            scan_reset <= !s2_q.program_restart_n;
        end
    end

    // readback ends once a full image of len bytes has been shifted out
    always_ff @(posedge clk) begin
        if (sys_rst || in_cfg) begin
            rb_active <= 1'b0;
            rb_start <= 1'b0;
            rb_addr_q <= '0;
        end else begin
            rb_start <= trig_fall && ctrl_q[CPC_CTRL_RB_POS];
            if (trig_fall && ctrl_q[CPC_CTRL_RB_POS]) begin
                rb_active <= 1'b1;
                rb_addr_q <= '0;
            end else if (rb_active && tick_q) begin
                rb_addr_q <= rb_addr_q + ADDR_OUT_W'(1);
                if (rb_addr_q == ADDR_OUT_W'({len_q, 3'h0}) -
                    ADDR_OUT_W'(1))
                    rb_active <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            serial_out <= 1'b0;
        end else begin
            serial_out <= rb_active ? rb_data_in : tdo_in;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence prog_low_s;
        !s2_q.program_restart_n;
    endsequence
    sequence rb_go_s;
        st_q == ST_USER && ctrl_q[CPC_CTRL_RB_POS] && trig_fall;
    endsequence

    a_prog_restart: assert property (prog_low_s |=> st_q == ST_CLEAR &&
        scan_reset) else $error("program low did not restart");
    a_reset_reload: assert property (st_q == ST_LOAD && s2_q.reset &&
        s2_q.program_restart_n |=> st_q == ST_CLEAR)
        else $error("reset pin did not restart the load");
    a_init_clear: assert property (st_q == ST_CLEAR && $past(st_q) ==
        ST_CLEAR |-> init_oe && !init_out) else $error("init not low");
    a_wait_hold: assert property (st_q == ST_WAIT && !s2_q.init &&
        s2_q.program_restart_n && !s2_q.reset |=> st_q == ST_WAIT)
        else $error("left wait state with init low");
    a_done_open: assert property (st_q == ST_LOAD |=> done_oe &&
        !done_out) else $error("completion pin released early");
    a_startup_hold: assert property (st_q == ST_DONE_WAIT &&
        !s2_q.done && s2_q.program_restart_n && !s2_q.reset |=>
        st_q == ST_DONE_WAIT) else $error("start-up ran with completion low");
    a_user_float: assert property (in_cfg |=> !user_io_en &&
        weak_pullup_en) else $error("user pins active in configuration");
    a_gts_trig: assert property (in_cfg && !s2_q.rb_trig_n |=>
        global_three_state) else $error("three-state not applied");
    a_rb_start: assert property (rb_go_s |=> rb_start && rb_active &&
        rb_addr_q == '0) else $error("readback did not start at frame 0");
    a_rdy_busy: assert property (st_q == ST_LOAD && mode_q ==
        CPC_MODE_APER && wr_fall && sel |=> !rdy_q ##1 !status_data_bit)
        else $error("ready not dropped after byte");
    a_config_clock_run: assert property (st_q == ST_LOAD && drive_clk &&
        !config_clock_q && config_clock_div_q == 8'(CPC_CONFIG_CLOCK_HALF_CYC - 1) |=> ##1
        config_clock_out) else $error("config clock not driven");
endmodule : cpc_config_ctrl

/* File: inc/cpc_pkg.sv */
package cpc_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [3:0] CPC_REG_CTRL = 4'h0;
    localparam logic [3:0] CPC_REG_LEN = 4'h4;
    localparam logic [3:0] CPC_REG_TIME = 4'h8;
    localparam logic [3:0] CPC_REG_STAT = 4'hc;
    localparam int CPC_CTRL_TS_POS = 0;
    localparam int CPC_CTRL_RB_POS = 1;
    localparam int CPC_CTRL_GSR_POS = 2;
    localparam logic [2:0] CPC_CTRL_RST = 3'h0;
    localparam logic [15:0] CPC_LEN_RST = 16'h0010;
    localparam logic [7:0] CPC_TIME_RST = 8'h11;
    localparam int CPC_TIME_DONE_POS = 0;
    localparam int CPC_TIME_REL_POS = 4;
    localparam int CPC_STAT_MODE_POS = 8;
    localparam int CPC_STAT_CNT_POS = 16;

    // ****************************************
    // configuration modes
    // ****************************************
    localparam logic [2:0] CPC_MODE_MSER = 3'h0;
    localparam logic [2:0] CPC_MODE_MPAR = 3'h1;
    localparam logic [2:0] CPC_MODE_APER = 3'h2;
    localparam logic [2:0] CPC_MODE_SPER = 3'h3;
    localparam logic [2:0] CPC_MODE_SPAR = 3'h4;
    localparam logic [2:0] CPC_MODE_SSER = 3'h7;

    // ****************************************
    // timing
    // ****************************************
    localparam int CPC_CLK_MHZ = 50;
    localparam int CPC_CONFIG_CLOCK_HALF_NS = 100;
    localparam int CPC_CONFIG_CLOCK_HALF_CYC =
        (CPC_CONFIG_CLOCK_HALF_NS * CPC_CLK_MHZ + 999) / 1000;
    localparam int CPC_CLEAR_NS = 1000;
    localparam int CPC_CLEAR_CYC = (CPC_CLEAR_NS * CPC_CLK_MHZ + 999) / 1000;

    typedef enum logic [6:0] {
        ST_CLEAR = 7'b0000001,
        ST_WAIT = 7'b0000010,
        ST_LOAD = 7'b0000100,
        ST_DONE_DLY = 7'b0001000,
        ST_DONE_WAIT = 7'b0010000,
        ST_STARTUP = 7'b0100000,
        ST_USER = 7'b1000000
    } cpc_state_t;

    // pins arriving from outside the clock domain
    typedef struct packed {
        logic program_restart_n;
        logic reset;
        logic rb_trig_n;
        logic init;
        logic done;
        logic config_clock;
        logic wr_n;
        logic rd_n;
        logic cs0_n;
        logic cs1;
        logic lsb_data_bit;
        logic [6:0] data_hi;
        logic [2:0] config_mode_select;
    } cpc_pins_t;
endpackage : cpc_pkg

/* File: testbench/cpc_src_model.sv */
`timescale 1ns/10ps
// ****************************************
// slave serial source, clock runs only in frames
// ****************************************
module cpc_src_model (
    input wire logic clk,
    input wire logic send,
    input wire logic [7:0] data,
    output logic config_clock,
    output logic serial_data,
    output logic busy
);
    int i;
    initial begin
        config_clock = 1'b0;
        serial_data = 1'b1;
        busy = 1'b0;
    end
    always begin
        @(posedge clk);
        if (send) begin
            busy <= 1'b1;
            for (i = 0; i < 8; i++) begin
                serial_data <= data[7-i];
                repeat (4) @(posedge clk);
                config_clock <= 1'b1;
                repeat (4) @(posedge clk);
                config_clock <= 1'b0;
            end
            // released line goes to the pull-up level
            serial_data <= 1'b1;
            busy <= 1'b0;
        end
    end
endmodule : cpc_src_model

/* File: testbench/cpc_config_ctrl_tb.sv */
`timescale 1ns/10ps
module cpc_config_ctrl_tb;
    import cpc_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    cpc_pins_t drv, pins;
    logic tdo_in = 1'b0, rb_data_in = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rd;
    logic ext_init_low = 1'b1, ext_done_low = 1'b0;
    logic init_oe, done_oe, cc_oe, ready_oe, vld, g3s, uio, wpu, lcsr;
    logic scan_reset, rb_start, rb_active, serial_out, seen, uri, sdo_oe;
    logic [7:0] cfg_byte, src_data = 8'h00;
    logic src_send = 1'b0, src_clk, src_dat, src_busy;
    logic [7:0] got_q[$];
    logic [7:0] sent [3];
    logic [2:0] modes [6] = '{CPC_MODE_MSER, CPC_MODE_MPAR, CPC_MODE_APER,
        CPC_MODE_SPER, CPC_MODE_SPAR, CPC_MODE_SSER};
    logic [3:0] ra [4] = '{CPC_REG_CTRL, CPC_REG_LEN, CPC_REG_TIME, 4'h2};
    logic [31:0] rv [4] = '{32'h0, 32'h10, 32'h11, 32'h0};
    logic [31:0] wv [4] = '{32'h6, 32'h3, 32'h21, 32'h5};
    int failures = 0;
    int total_checks = 0;

    always #10 clk = ~clk;

    always_comb begin
        pins = drv;
        pins.config_clock = src_clk;
        pins.lsb_data_bit = src_dat;
        pins.init = !init_oe && !ext_init_low;
        pins.done = !done_oe && !ext_done_low;
    end

    always @(posedge clk) if (vld === 1'b1) got_q.push_back(cfg_byte);

    cpc_config_ctrl cpc_config_ctrl_i (.clk(clk), .sys_rst(sys_rst),
        .pins_in(pins), .tdo_in(tdo_in), .rb_data_in(rb_data_in),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .init_out(),
        .init_oe(init_oe), .done_out(), .done_oe(done_oe),
        .config_clock_out(), .config_clock_oe(cc_oe), .ready_out(),
        .ready_oe(ready_oe), .status_data_bit(), .status_data_oe(sdo_oe),
        .mem_addr(), .serial_out(serial_out), .cfg_byte(cfg_byte),
        .cfg_byte_vld(vld), .global_three_state(g3s), .user_io_en(uio),
        .weak_pullup_en(wpu), .logic_cell_set_reset(lcsr),
        .user_reset_in(uri), .scan_reset(scan_reset), .rb_start(rb_start),
        .rb_active(rb_active));

    cpc_src_model cpc_src_model_i (.clk(clk), .send(src_send),
        .data(src_data), .config_clock(src_clk), .serial_data(src_dat),
        .busy(src_busy));

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic report_and_stop;
        if (failures == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rdr(input logic [3:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
        @(posedge clk);
    endtask : rdr

    task automatic wait_state(input logic [6:0] s);
        int n = 0;
        rdr(CPC_REG_STAT);
        while (rd[6:0] !== s) begin
            n++;
            if (n > 200) begin
                failures++;
                report_and_stop();
            end
            rdr(CPC_REG_STAT);
        end
    endtask : wait_state

    task automatic send_byte(input logic [7:0] b);
        int n = 0;
        src_data <= b;
        src_send <= 1'b1;
        @(posedge clk);
        src_send <= 1'b0;
        #1;
        while (src_busy && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 200) begin
            failures++;
            report_and_stop();
        end
        @(posedge clk);
    endtask : send_byte

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        drv = '1;
        drv.reset = 1'b0;
        drv.cs1 = 1'b0;
        drv.data_hi = 7'h00;
        drv.config_mode_select = CPC_MODE_SSER;
        drv.rb_trig_n = 1'b1;
        void'($urandom(68267));
        cyc(5);
        sys_rst <= 1'b0;
        #1;
        chk(init_oe, 1'b1);
        chk(done_oe, 1'b1);
        chk(wpu, 1'b1);
        chk(uio, 1'b0);
        @(posedge clk);
        for (int k = 0; k < 4; k++) begin
            rdr(ra[k]);
            chk(rd, rv[k]);
            wr(ra[k], 32'h6 | wv[k]);
            wr(ra[k], wv[k]);
            rdr(ra[k]);
            chk(rd, k < 3 ? wv[k] : 32'h0);
        end
        // init held low from outside keeps the wait state
        cyc(80);
        rdr(CPC_REG_STAT);
        chk(rd[6:0], 7'h02);
        chk(init_oe, 1'b0);
        ext_init_low <= 1'b0;
        for (int k = 0; k < 6; k++) begin
            drv.config_mode_select <= modes[k];
            drv.program_restart_n <= 1'b0;
            cyc(5);
            chk(scan_reset, 1'b1);
            drv.program_restart_n <= 1'b1;
            wait_state(7'h04);
            rdr(CPC_REG_STAT);
            chk(rd[10:8], modes[k]);
            chk(cc_oe, k < 3);
            chk(ready_oe, k > 0 && k < 4);
            if (k == 2) begin
                // one written byte, then a status read with trigger low
                drv.cs0_n <= 1'b0;
                drv.cs1 <= 1'b1;
                drv.wr_n <= 1'b0;
                cyc(2);
                drv.wr_n <= 1'b1;
                drv.rd_n <= 1'b0;
                drv.rb_trig_n <= 1'b0;
                cyc(4);
                chk(sdo_oe, 1'b1);
                chk(g3s, 1'b1);
                drv.rd_n <= 1'b1;
                drv.cs0_n <= 1'b1;
                drv.cs1 <= 1'b0;
                drv.rb_trig_n <= 1'b1;
            end
        end
        drv.reset <= 1'b1;
        cyc(5);
        rdr(CPC_REG_STAT);
        chk(rd[6:0], 7'h01);
        drv.reset <= 1'b0;
        wait_state(7'h04);
        got_q.delete();
        ext_done_low <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            sent[k] = 8'($urandom);
            send_byte(sent[k]);
        end
        cyc(4);
        chk(got_q.size(), 3);
        for (int k = 0; k < got_q.size() && k < 3; k++)
            chk(got_q[k], sent[k]);
        send_byte(8'hff);
        cyc(6);
        chk(done_oe, 1'b0);
        rdr(CPC_REG_STAT);
        chk(rd[6:0], 7'h10);
        chk(uio, 1'b0);
        ext_done_low <= 1'b0;
        send_byte(8'hff);
        cyc(6);
        rdr(CPC_REG_STAT);
        chk(rd[6:0], 7'h40);
        chk(uio, 1'b1);
        chk(wpu, 1'b0);
        chk(cc_oe, 1'b0);
        drv.reset <= 1'b1;
        cyc(5);
        chk(lcsr, 1'b1);
        chk(uri, 1'b1);
        drv.reset <= 1'b0;
        tdo_in <= 1'b1;
        cyc(5);
        chk(lcsr, 1'b0);
        chk(uri, 1'b0);
        chk(serial_out, 1'b1);
        // trigger fall starts readback, option keeps pins driven
        drv.rb_trig_n <= 1'b0;
        seen = 1'b0;
        repeat (10) begin
            @(posedge clk);
            if (rb_start === 1'b1) seen = 1'b1;
        end
        chk(seen, 1'b1);
        chk(rb_active, 1'b1);
        chk(g3s, 1'b0);
        chk(uio, 1'b1);
        rb_data_in <= 1'b1;
        tdo_in <= 1'b0;
        cyc(4);
        chk(serial_out, 1'b1);
        rb_data_in <= 1'b0;
        tdo_in <= 1'b1;
        cyc(4);
        chk(serial_out, 1'b0);
        drv.rb_trig_n <= 1'b1;
        drv.program_restart_n <= 1'b0;
        cyc(6);
        chk(uio, 1'b0);
        rdr(CPC_REG_STAT);
        chk(rd[6:0], 7'h01);
        report_and_stop();
    end
endmodule : cpc_config_ctrl_tb
